// ===== hw/ctrl_word_pkg.sv
package ctrl_word_pkg;

  localparam int WORD_W   = 16;
  localparam int PARAM_W  = 16;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // Control word bit positions
  localparam int BIT_STOP   = 0;
  localparam int BIT_START  = 1;
  localparam int BIT_OPTION = 2;
  localparam int BIT_CLEAR  = 3;

  // Source mask values
  localparam logic [7:0] MASK_STOP_ONLY = 8'h00;
  localparam logic [7:0] MASK_FULL      = 8'h04;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL_WORD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SRC_MASK  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PARAM     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ACTIVE    = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 8'h18;

  // Event bits in interrupt status and mask
  localparam int EV_W      = 4;
  localparam int EV_START  = 0;
  localparam int EV_STOP   = 1;
  localparam int EV_OPTION = 2;
  localparam int EV_FAULT  = 3;

  // Motor state bits; the status register puts comm fault at bit 2 and pending parameter at bit 3
  localparam int ST_RUN   = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_PEND  = 2;
  localparam int ST_COMM  = 3;

  localparam logic [WORD_W-1:0]  WORD_RESET  = 16'h0000;
  localparam logic [PARAM_W-1:0] PARAM_RESET = 16'h0000;
  localparam logic [7:0]         SMASK_RESET = 8'h00;
  localparam logic [EV_W-1:0]    EV_ZERO     = 4'h0;

  typedef struct packed {
    logic clear;
    logic option;
    logic start;
    logic stop;
  } cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

endpackage : ctrl_word_pkg

// ===== hw/edge_track.sv
`timescale 1ns/1ps
`default_nettype none

module edge_track #(
  parameter int W = 16
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] cur_i,
  output var  logic [W-1:0] prev_o,
  output var  logic [W-1:0] rise_o
);

  import ctrl_word_pkg::*;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prev_o <= '0;
    end else begin
      prev_o <= cur_i;
    end
  end

  always_comb begin
    rise_o = cur_i & ~prev_o;
  end

endmodule : edge_track

`default_nettype wire

// ===== hw/motor_starter_control_word.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Word bit0 stop, bit1 start, bit2 option, bit3 clear; bits 4-15 ignored.
// - Stop with any other bit: act on stop, drop the rest.
// - While stop held, other bits ignored until stop returns to zero.
// - Start and fault clear act only on a 0 to 1 transition.
// - Option bit begins the installed option manoeuvre.
// - Parameter written while running takes effect at the next start.
// - Unless source mask is 4, only stop from the port acts.
// - Module removed while mask is 4 raises communication-loss fault.
module motor_starter_control_word
  import ctrl_word_pkg::*;
(
  input  wire logic                             clk_sys_i,
  input  wire logic                             rst_i,
  input  wire logic                             module_present_i,
  input  wire logic                             word_valid_i,
  input  wire logic [ctrl_word_pkg::WORD_W-1:0] word_i,
  input  wire logic [ctrl_word_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [ctrl_word_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                             wr_i,
  input  wire logic                             rd_i,
  output var  logic [ctrl_word_pkg::DATA_W-1:0] rdata_o,
  output var  logic                             motor_run_o,
  output var  logic                             start_pulse_o,
  output var  logic                             stop_pulse_o,
  output var  logic                             option_pulse_o,
  output var  logic                             fault_o,
  output var  logic                             comm_fault_o,
  output var  logic [ctrl_word_pkg::PARAM_W-1:0] param_active_o,
  output var  logic                             irq_o
);

  import ctrl_word_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic        present_s1;
  logic        present_s2;
  logic        present_q;
  logic [WORD_W-1:0] word_s1;
  logic [WORD_W-1:0] word_s2;
  logic        valid_s1;
  logic        valid_s2;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      present_s1 <= 1'b0;
      present_s2 <= 1'b0;
      present_q  <= 1'b0;
      word_s1    <= WORD_RESET;
      word_s2    <= WORD_RESET;
      valid_s1   <= 1'b0;
      valid_s2   <= 1'b0;
    end else begin
      present_s1 <= module_present_i;
      present_s2 <= present_s1;
      present_q  <= present_s2;
      word_s1    <= word_i;
      word_s2    <= word_s1;
      valid_s1   <= word_valid_i;
      valid_s2   <= valid_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [WORD_W-1:0]  sw_word;
  logic [7:0]         src_mask;
  logic [PARAM_W-1:0] param_pend;
  logic [EV_W-1:0]    irq_stat;
  logic [EV_W-1:0]    irq_mask;

  wire sel_word  = (addr_i == REG_CTRL_WORD);
  wire sel_mask  = (addr_i == REG_SRC_MASK);
  wire sel_param = (addr_i == REG_PARAM);
  wire sel_act   = (addr_i == REG_ACTIVE);
  wire sel_stat  = (addr_i == REG_STATUS);
  wire sel_istat = (addr_i == REG_IRQ_STAT);
  wire sel_imask = (addr_i == REG_IRQ_MASK);

  // Only the two legal mask values are accepted
  wire mask_legal = (wdata_i[7:0] == MASK_STOP_ONLY) || (wdata_i[7:0] == MASK_FULL);

  ////////////////////////////////////////////////////////////////////////
  // Command word source and decode

  // The module's word is used while present and valid; otherwise the word register
  wire [WORD_W-1:0] word_src = (present_s2 && valid_s2) ? word_s2 : sw_word;
  wire              full_ctl = (src_mask == MASK_FULL);

  cmd_t cmd_now;
  assign cmd_now.stop   = word_src[BIT_STOP];
  assign cmd_now.start  = word_src[BIT_START];
  assign cmd_now.option = word_src[BIT_OPTION];
  assign cmd_now.clear  = word_src[BIT_CLEAR];

  logic [EV_W-1:0] prev_bits;
  logic [EV_W-1:0] rise_bits;

  edge_track #(
    .W (EV_W)
  ) u_edge (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .cur_i     (cmd_now),
    .prev_o    (prev_bits),
    .rise_o    (rise_bits)
  );

  // Stop always acts; others need full control and no stop present
  wire other_ok    = full_ctl && !cmd_now.stop;
  wire start_req   = other_ok && rise_bits[BIT_START];
  wire clear_req   = other_ok && rise_bits[BIT_CLEAR];
  wire option_req  = other_ok && rise_bits[BIT_OPTION];
  wire stop_req    = cmd_now.stop;
  wire comm_lost   = full_ctl && present_q && !present_s2;

  ////////////////////////////////////////////////////////////////////////
  // Motor state

  logic param_dirty;
  logic fault_int;
  logic comm_int;

  wire fault_any   = fault_int || comm_int;
  wire start_go    = start_req && !fault_any && !motor_run_o;
  wire stop_go     = stop_req && motor_run_o;
  wire option_go   = option_req && motor_run_o;
  wire [EV_W-1:0] events = {comm_lost, option_go, stop_go, start_go};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      motor_run_o    <= 1'b0;
      start_pulse_o  <= 1'b0;
      stop_pulse_o   <= 1'b0;
      option_pulse_o <= 1'b0;
      param_active_o <= PARAM_RESET;
      param_dirty    <= 1'b0;
    end else begin
      start_pulse_o  <= start_go;
      stop_pulse_o   <= stop_go;
      option_pulse_o <= option_go;
      if (stop_go || option_go || comm_lost) begin
        motor_run_o <= 1'b0;
      end else if (start_go) begin
        motor_run_o <= 1'b1;
      end
      if (start_go) begin
        param_active_o <= param_pend;
        param_dirty    <= 1'b0;
      end else if (wr_i && sel_param && motor_run_o) begin
        param_dirty <= 1'b1;
      end else if (wr_i && sel_param) begin
        param_active_o <= wdata_i[PARAM_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_int    <= 1'b0;
      comm_int     <= 1'b0;
      fault_o      <= 1'b0;
      comm_fault_o <= 1'b0;
    end else begin
      if (comm_lost) begin
        comm_int <= 1'b1;
      end else if (clear_req) begin
        comm_int <= 1'b0;
      end
      fault_int    <= fault_int && !clear_req;
      fault_o      <= fault_any;
      comm_fault_o <= comm_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes and interrupts

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sw_word    <= WORD_RESET;
      src_mask   <= SMASK_RESET;
      param_pend <= PARAM_RESET;
      irq_mask   <= EV_ZERO;
      irq_stat   <= EV_ZERO;
      irq_o      <= 1'b0;
    end else begin
      if (wr_i && sel_word) begin
        sw_word <= wdata_i[WORD_W-1:0];
      end
      if (wr_i && sel_mask && mask_legal) begin
        src_mask <= wdata_i[7:0];
      end
      if (wr_i && sel_param) begin
        param_pend <= wdata_i[PARAM_W-1:0];
      end
      if (wr_i && sel_imask) begin
        irq_mask <= wdata_i[EV_W-1:0];
      end
      // Set wins over write-one-to-clear
      if (wr_i && sel_istat) begin
        irq_stat <= (irq_stat & ~wdata_i[EV_W-1:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read

  wire [DATA_W-1:0] status_word = {28'h0000000, param_dirty, comm_int, fault_any, motor_run_o};
  wire [DATA_W-1:0] rd_mux =
    sel_word  ? {16'h0000, sw_word} :
    sel_mask  ? {24'h000000, src_mask} :
    sel_param ? {16'h0000, param_pend} :
    sel_act   ? {16'h0000, param_active_o} :
    sel_stat  ? status_word :
    sel_istat ? {28'h0000000, irq_stat} :
    sel_imask ? {28'h0000000, irq_mask} :
    32'h00000000;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

endmodule : motor_starter_control_word

`default_nettype wire

// ===== verif/msc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////
module msc_monitor
  import ctrl_word_pkg::*;
(
  input wire logic                              clk_sys_i,
  input wire logic                              rst_i,
  input wire logic                              word_valid_i,
  input wire logic [ctrl_word_pkg::ADDR_W-1:0]  addr_i,
  input wire logic [ctrl_word_pkg::DATA_W-1:0]  wdata_i,
  input wire logic                              wr_i,
  input wire logic                              rd_i,
  input wire logic [ctrl_word_pkg::DATA_W-1:0]  rdata_o,
  input wire logic                              motor_run_o,
  input wire logic                              start_pulse_o,
  input wire logic                              stop_pulse_o,
  input wire logic                              option_pulse_o,
  input wire logic                              fault_o,
  input wire logic                              comm_fault_o,
  input wire logic [ctrl_word_pkg::PARAM_W-1:0] param_active_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic sw_wr;
  assign sw_wr = wr_i && addr_i == REG_CTRL_WORD && !word_valid_i;
  chk_start_edge: assert property (start_pulse_o |-> motor_run_o && !$past(motor_run_o))
    else $error("start pulse while already running");
  chk_start_once: assert property (start_pulse_o |=> !start_pulse_o [*2])
    else $error("start pulse repeated");
  chk_stop_wins: assert property (sw_wr && wdata_i[0] |-> ##2 !start_pulse_o && !option_pulse_o)
    else $error("start or option acted beside stop");
  chk_stop_halts: assert property (stop_pulse_o |-> !motor_run_o)
    else $error("motor still running after stop");
  chk_option_halts: assert property (option_pulse_o |-> !motor_run_o && $past(motor_run_o))
    else $error("option pulse without run to stop step");
  chk_param_frozen: assert property (motor_run_o && $past(motor_run_o) |-> $stable(param_active_o))
    else $error("active parameter changed while running");
  chk_comm_fault: assert property (comm_fault_o |-> fault_o)
    else $error("comm fault without fault flag");
  chk_comm_stops: assert property ($rose(comm_fault_o) |-> ##[0:2] !motor_run_o)
    else $error("motor kept running after comm loss");
  chk_rd_quiet: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data outside read slot");
endmodule : msc_monitor
bind motor_starter_control_word msc_monitor mon (.*);
`default_nettype wire

// ===== verif/plc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////
module plc_link_model (
  input  wire logic                             clk_sys_i,
  input  wire logic                             plug_i,
  input  wire logic [ctrl_word_pkg::WORD_W-1:0] cmd_i,
  output var  logic                             present_o,
  output var  logic                             valid_o,
  output var  logic [ctrl_word_pkg::WORD_W-1:0] word_o
);
  initial begin
    present_o = 1'b0;
    valid_o   = 1'b0;
    word_o    = 16'h0000;
  end
  // Unplugged: word line toggles, never holds last value
  always @(posedge clk_sys_i) begin
    present_o <= plug_i;
    valid_o   <= plug_i;
    word_o    <= plug_i ? cmd_i : ~word_o;
  end
endmodule : plc_link_model
`default_nettype wire

// ===== verif/motor_starter_control_word_bench.sv
`timescale 1ns/1ps
`default_nettype none
module motor_starter_control_word_bench;
  import ctrl_word_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, plug = 0;
  logic module_present_i, word_valid_i, motor_run_o, start_pulse_o, stop_pulse_o;
  logic option_pulse_o, fault_o, comm_fault_o, irq_o;
  logic [15:0] word_i, param_active_o, cmd = 0;
  logic [7:0]  addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o;
  int n_fail = 0, total_checks = 0, n_st = 0, n_sp = 0, n_op = 0;
  motor_starter_control_word DUT (.*);
  plc_link_model plc (.clk_sys_i(clk_sys_i), .plug_i(plug), .cmd_i(cmd),
    .present_o(module_present_i), .valid_o(word_valid_i), .word_o(word_i));
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    n_st += start_pulse_o;
    n_sp += stop_pulse_o;
    n_op += option_pulse_o;
  end
  //////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 chk("rdata", rdata_o, e);
  endtask : rchk
  task automatic cw(input logic [15:0] d, input int es, input int ep, input int eo, input logic r);
    int s0, p0, o0;
    s0 = n_st;
    p0 = n_sp;
    o0 = n_op;
    wr(REG_CTRL_WORD, {16'h0000, d});
    cyc(4);
    #1 chk("start", n_st - s0, es);
    chk("stop", n_sp - p0, ep);
    chk("option", n_op - o0, eo);
    chk("run", motor_run_o, r);
  endtask : cw
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////
  task automatic t_reset;
    chk("run", {motor_run_o, fault_o, irq_o}, 3'h0);
    rchk(REG_SRC_MASK, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    cw(16'h0002, 0, 0, 0, 1'b0);
    wr(REG_SRC_MASK, 32'h0000_0005);
    rchk(REG_SRC_MASK, 32'h0000_0000);
    wr(REG_SRC_MASK, 32'h0000_0004);
    rchk(REG_SRC_MASK, 32'h0000_0004);
    $display("reset test done");
  endtask : t_reset
  task automatic t_bits;
    cw(16'hFFF0, 0, 0, 0, 1'b0);
    cw(16'hFFF2, 1, 0, 0, 1'b1);
    cw(16'h0002, 0, 0, 0, 1'b1);
    cw(16'h0003, 0, 1, 0, 1'b0);
    cw(16'h0001, 0, 0, 0, 1'b0);
    cw(16'h0003, 0, 0, 0, 1'b0);
    cw(16'h0002, 0, 0, 0, 1'b0);
    cw(16'h0000, 0, 0, 0, 1'b0);
    cw(16'h0002, 1, 0, 0, 1'b1);
    cw(16'h0004, 0, 0, 1, 1'b0);
    $display("bits test done");
  endtask : t_bits
  task automatic t_param;
    cw(16'h0000, 0, 0, 0, 1'b0);
    wr(REG_PARAM, 32'h0000_1234);
    rchk(REG_ACTIVE, 32'h0000_1234);
    cw(16'h0002, 1, 0, 0, 1'b1);
    wr(REG_PARAM, 32'h0000_5678);
    cyc(3);
    #1 chk("param", param_active_o, 16'h1234);
    rchk(REG_STATUS, 32'h0000_0009);
    cw(16'h0001, 0, 1, 0, 1'b0);
    cw(16'h0000, 0, 0, 0, 1'b0);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    wr(REG_IRQ_STAT, 32'h0000_000F);
    cw(16'h0002, 1, 0, 0, 1'b1);
    chk("param", param_active_o, 16'h5678);
    chk("irq", irq_o, 1'b1);
    wr(REG_IRQ_STAT, 32'h0000_0001);
    cw(16'h0001, 0, 1, 0, 1'b0);
    chk("irq", irq_o, 1'b0);
    rchk(REG_IRQ_STAT, 32'h0000_0002);
    $display("param test done");
  endtask : t_param
  task automatic t_comm;
    cw(16'h0000, 0, 0, 0, 1'b0);
    plug <= 1'b1;
    cyc(6);
    cmd <= 16'h0002;
    cyc(6);
    #1 chk("pin run", motor_run_o, 1'b1);
    plug <= 1'b0;
    cyc(6);
    #1 chk("comm", {comm_fault_o, fault_o, motor_run_o}, 3'h6);
    cmd  <= 16'h0000;
    plug <= 1'b1;
    cyc(6);
    cmd <= 16'h0008;
    cyc(6);
    #1 chk("clear", {comm_fault_o, fault_o}, 2'h0);
    $display("comm test done");
  endtask : t_comm
  //////////////////////////////////////////////////
  initial begin
    cyc(4);
    rst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_bits();
    t_param();
    t_comm();
    final_report();
  end
  initial begin
    cyc(20000);
    n_fail++;
    final_report();
  end
endmodule : motor_starter_control_word_bench
`default_nettype wire
